// ### logic/cipu_defines.vh
// constants for the cascaded interrupt priority unit
`ifndef CIPU_DEFINES_VH
`define CIPU_DEFINES_VH

// =====================================================================
// line counts and cascade position
`define CIPU_LINES        16
`define CIPU_CASCADE_LINE 3'h2
`define CIPU_CASCADE_BIT  8'h04
`define CIPU_CHK_BIT      16
`define CIPU_SMI_BIT      17

// =====================================================================
// reset values
`define CIPU_MASK_RST     16'hffff
`define CIPU_VEC_PRI_RST  8'h08
`define CIPU_VEC_SEC_RST  8'h70
`define CIPU_VEC_NMI      8'h02
`define CIPU_VEC_OUT_RST  8'h00
`define CIPU_SYNC_RST     18'h00000

`endif

// ### logic/cipu_pri8.v
// one eight-line priority controller with request, mask and service state
`timescale 1ns/1ps
`default_nettype none

module cipu_pri8 (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] req_set,
    input  wire [7:0] req_lvl,
    input  wire [7:0] mask,
    input  wire       ack,
    input  wire       eoi,
    output wire       int_req,
    output wire [2:0] win_idx
);

    reg  [7:0] irr_reg;
    reg  [7:0] isr_reg;
    reg  [7:0] irr_next;
    reg  [7:0] isr_next;
    wire [7:0] pend;
    wire [3:0] p_win;
    wire [3:0] s_win;

    // =================================================================
    // lowest numbered set bit wins: {found, index}
    function [3:0] cipu_first;
        input [7:0] v;
        integer i;
        begin
            cipu_first = 4'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    cipu_first = {1'b1, i[2:0]};
                end
            end
        end
    endfunction

    // =================================================================
    // resolve the winner against what is already in service
    assign pend    = (irr_reg | req_lvl) & ~mask;
    assign p_win   = cipu_first(pend);
    assign s_win   = cipu_first(isr_reg);
    assign win_idx = p_win[2:0];
    // equal or lower priority waits for end of interrupt
    assign int_req = p_win[3] & (~s_win[3] | (p_win[2:0] < s_win[2:0]));

    // next request and service state; a new edge beats the ack clear
    always @* begin
        irr_next = irr_reg | req_set;
        isr_next = isr_reg;
        if (eoi && s_win[3]) begin
            isr_next[s_win[2:0]] = 1'b0;
        end
        if (ack && int_req) begin
            isr_next[p_win[2:0]] = 1'b1;
            irr_next[p_win[2:0]] = req_set[p_win[2:0]];
        end
    end

    // state registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irr_reg <= 8'h00;
            isr_reg <= 8'h00;
        end else begin
            irr_reg <= irr_next;
            isr_reg <= isr_next;
        end
    end

endmodule

`default_nettype wire

// ### logic/cipu_top.v
// top of the cascaded interrupt priority unit: two controllers, nmi, smi
`timescale 1ns/1ps
`default_nettype none
`include "cipu_defines.vh"

// Function
// - request pins 0 to 15 are taken except pin 2, whose primary line the cascade uses.
// - the secondary controller's request drives primary line 2.
// - on the primary, line 0 has the highest priority and line 7 lowest.
// - on the secondary, line 8 is highest and 15 lowest, above 3 to 7.
// - after power-up every line is masked until software unmasks it.
// - the primary returns vector 08h plus its line number.
// - the secondary returns vector 70h plus its line offset.
// - the system-management input ignores every mask.
// - the non-maskable request follows channel check, vector 2.
module cipu_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [15:0] irq_pin,
    input  wire        chan_chk_pin,
    input  wire        smi_pin,
    input  wire        mask_wr,
    input  wire [15:0] mask_data,
    input  wire        vec_wr,
    input  wire [7:0]  vec_pri_data,
    input  wire [7:0]  vec_sec_data,
    input  wire        inta,
    input  wire        eoi_pri,
    input  wire        eoi_sec,
    output reg         int_out,
    output reg  [7:0]  vector_out,
    output reg         vector_valid,
    output reg         nmi_out,
    output reg  [7:0]  nmi_vector,
    output reg         smi_out,
    output reg  [15:0] mask_out
);

    // =================================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    reg  [17:0] sync1_reg;
    reg  [17:0] sync2_reg;
    reg  [17:0] sync3_reg;
    reg  [17:0] filt_reg;
    wire [17:0] pin_bus;
    wire [17:0] agree;
    wire [17:0] rise;
    wire [15:0] line_rise;
    wire        chk_lvl;
    wire        smi_lvl;

    // gather the asynchronous pins into one bundle
    assign pin_bus = {smi_pin, chan_chk_pin, irq_pin};

    // a level is trusted only once stages two and three match
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign rise  = agree & sync3_reg & ~filt_reg;

    // three-stage sampling chain, reset to the idle low level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `CIPU_SYNC_RST;
            sync2_reg <= `CIPU_SYNC_RST;
            sync3_reg <= `CIPU_SYNC_RST;
        end else begin
            sync1_reg <= pin_bus;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // filtered level follows stage three only while the stages agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_reg <= `CIPU_SYNC_RST;
        end else begin
            filt_reg <= (filt_reg & ~agree) | (sync3_reg & agree);
        end
    end

    // split the filtered bundle back into its meanings
    assign line_rise = rise[`CIPU_LINES-1:0];
    assign chk_lvl   = filt_reg[`CIPU_CHK_BIT];
    assign smi_lvl   = filt_reg[`CIPU_SMI_BIT];

    // =================================================================
    // mask and vector base state
    reg [15:0] mask_reg;
    reg [7:0]  vec_pri_reg;
    reg [7:0]  vec_sec_reg;

    // all lines masked from reset until software opens them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= `CIPU_MASK_RST;
        end else if (mask_wr) begin
            mask_reg <= mask_data;
        end
    end

    // vector bases start at their defaults and may be reloaded
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_pri_reg <= `CIPU_VEC_PRI_RST;
            vec_sec_reg <= `CIPU_VEC_SEC_RST;
        end else if (vec_wr) begin
            vec_pri_reg <= vec_pri_data;
            vec_sec_reg <= vec_sec_data;
        end
    end

    // =================================================================
    // vector is the controller's base plus the winning line's index
    function [7:0] cipu_vec;
        input [7:0] base;
        input [2:0] idx;
        begin
            cipu_vec = base + {5'h00, idx};
        end
    endfunction

    // =================================================================
    // the two controllers, secondary cascaded onto primary line 2
    wire       pri_int;
    wire [2:0] pri_idx;
    wire       sec_int;
    wire [2:0] sec_idx;
    wire       take;
    wire       take_cas;
    wire [7:0] pri_set;
    wire [7:0] pri_lvl;

    // an acknowledge counts only while the primary has a winner
    assign take     = inta & pri_int;
    assign take_cas = take & (pri_idx == `CIPU_CASCADE_LINE);

    // cascade input is the secondary's level, never an edge on pin 2
    assign pri_set  = line_rise[7:0] & ~`CIPU_CASCADE_BIT;
    assign pri_lvl  = sec_int ? `CIPU_CASCADE_BIT : 8'h00;

    // lines 0 to 7
    cipu_pri8 u_pri (
        .clk     (clk),
        .rst_n   (rst_n),
        .req_set (pri_set),
        .req_lvl (pri_lvl),
        .mask    (mask_reg[7:0]),
        .ack     (take),
        .eoi     (eoi_pri),
        .int_req (pri_int),
        .win_idx (pri_idx)
    );

    // lines 8 to 15
    cipu_pri8 u_sec (
        .clk     (clk),
        .rst_n   (rst_n),
        .req_set (line_rise[15:8]),
        .req_lvl (8'h00),
        .mask    (mask_reg[15:8]),
        .ack     (take_cas),
        .eoi     (eoi_sec),
        .int_req (sec_int),
        .win_idx (sec_idx)
    );

    // =================================================================
    // processor side: request level, dropped while answering
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_out <= 1'b0;
        end else begin
            int_out <= pri_int & ~take;
        end
    end

    // answer strobe, one cycle after a taken acknowledge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_valid <= 1'b0;
        end else begin
            vector_valid <= take;
        end
    end

    // the vector holds until the next answer replaces it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_out <= `CIPU_VEC_OUT_RST;
        end else if (take_cas) begin
            vector_out <= cipu_vec(vec_sec_reg, sec_idx);
        end else if (take) begin
            vector_out <= cipu_vec(vec_pri_reg, pri_idx);
        end
    end

    // =================================================================
    // side interrupts: channel check and system management
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_out    <= 1'b0;
            nmi_vector <= `CIPU_VEC_NMI;
            smi_out    <= 1'b0;
        end else begin
            nmi_out    <= chk_lvl;
            nmi_vector <= `CIPU_VEC_NMI;
            smi_out    <= smi_lvl;                     // no mask term
        end
    end

    // =================================================================
    // mask mirror for the processor
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_out <= `CIPU_MASK_RST;
        end else begin
            mask_out <= mask_reg;
        end
    end

endmodule

`default_nettype wire

// ### test/cipu_sva.sv
// port checks for the cascaded interrupt priority unit
`timescale 1ns/1ps
`default_nettype none
module cipu_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        chan_chk_pin,
    input wire logic        smi_pin,
    input wire logic        mask_wr,
    input wire logic        inta,
    input wire logic        int_out,
    input wire logic [7:0]  vector_out,
    input wire logic        vector_valid,
    input wire logic        nmi_out,
    input wire logic [7:0]  nmi_vector,
    input wire logic        smi_out,
    input wire logic [15:0] mask_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // side inputs, masking and answers
    property p_nmiv; nmi_vector == 8'h02; endproperty
    a_nmiv: assert property (p_nmiv) else $error("nmi vector");
    property p_nmi; chan_chk_pin [*8] |-> nmi_out; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi level");
    property p_smi; smi_pin [*8] |-> smi_out; endproperty
    a_smi: assert property (p_smi) else $error("smi masked");
    property p_msk; (mask_out == 16'hffff) [*3] |-> !int_out; endproperty
    a_msk: assert property (p_msk) else $error("masked int");
    property p_mchg;
        $changed(mask_out) |-> $past(mask_wr) || $past(mask_wr, 2);
    endproperty
    a_mchg: assert property (p_mchg) else $error("mask moved");
    property p_ack; inta && int_out |=> vector_valid ##1 !vector_valid;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_vec;
        vector_valid |-> vector_out[7:3] == 5'h01 || vector_out[7:3] == 5'h0e;
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_ans; vector_valid |-> $past(inta) && !int_out; endproperty
    a_ans: assert property (p_ans) else $error("stray answer");
    c_sec: cover property (vector_valid && vector_out == 8'h70);
    c_casc: cover property (vector_valid && vector_out == 8'h71);
    c_smi: cover property (smi_out && nmi_out);
endmodule
`default_nettype wire

// ### test/cipu_host.sv
// host model: loads vector bases, acknowledges requests
`timescale 1ns/1ps
`default_nettype none
module cipu_host (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [3:0] lat,
    input  wire logic       int_out,
    input  wire logic       vector_valid,
    input  wire logic [7:0] vector_out,
    output logic            inta,
    output logic            vec_wr,
    output logic [7:0]      vec_pri_data,
    output logic [7:0]      vec_sec_data,
    output logic [7:0]      soft_vec
);
    logic [3:0] wait_reg;
    logic       busy_reg;
    logic       init_reg;
    assign vec_pri_data = 8'h08;
    assign vec_sec_data = 8'h70;
    // firmware table sends line 9's vector on to the cascade slot 0ah
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            soft_vec <= 8'h00;
        else if (vector_valid)
            soft_vec <= (vector_out == vec_sec_data + 8'h01) ? 8'h0a
                                                             : vector_out;
    end
    // one base load after reset, then one inta per request after lat
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inta     <= 1'b0;
            vec_wr   <= 1'b0;
            init_reg <= 1'b0;
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
        end else begin
            vec_wr   <= !init_reg;
            init_reg <= 1'b1;
            inta     <= 1'b0;
            if (vector_valid)
                busy_reg <= 1'b0;
            if (inta || !en || !int_out || busy_reg)
                wait_reg <= 4'h0;
            else if (wait_reg == lat) begin
                inta     <= 1'b1;
                busy_reg <= 1'b1;
            end else
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// testbench for the cascaded interrupt priority unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, chan_chk_pin = 1'b0;
    logic        smi_pin = 1'b0, mask_wr = 1'b0, en = 1'b0;
    logic        eoi_pri = 1'b0, eoi_sec = 1'b0;
    logic [15:0] irq_pin = 16'h0000, mask_data = 16'hffff, mask_out;
    logic [3:0]  lat = 4'h0;
    logic        inta, vec_wr, int_out, vector_valid, nmi_out, smi_out;
    logic [7:0]  vec_pri_data, vec_sec_data, vector_out, nmi_vector, soft_vec;
    int          n_errors = 0, checks = 0, cyc = 0;
    cipu_top cipu_top_i (.clk, .rst_n, .irq_pin, .chan_chk_pin, .smi_pin,
        .mask_wr, .mask_data, .vec_wr, .vec_pri_data, .vec_sec_data, .inta,
        .eoi_pri, .eoi_sec, .int_out, .vector_out, .vector_valid, .nmi_out,
        .nmi_vector, .smi_out, .mask_out);
    cipu_host cipu_host_i (.clk, .rst_n, .en, .lat, .int_out, .vector_valid,
        .vector_out, .inta, .vec_wr, .vec_pri_data, .vec_sec_data, .soft_vec);
    always #12.5 clk = ~clk;
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            finish_test();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task set_mask(input logic [15:0] m);
        mask_data = m;
        mask_wr = 1'b1;
        tick(1);
        mask_wr = 1'b0;
        tick(2);
        chk(mask_out, m);
    endtask
    // one answer, then nothing lower may come until eoi
    task serve(input logic [7:0] v, input logic sec);
        int i;
        i = 0;
        while (vector_valid !== 1'b1 && i < 60) begin
            tick(1);
            i++;
        end
        chk({7'h00, vector_valid, vector_out}, {8'h01, v});
        repeat (10) begin
            tick(1);
            if (vector_valid === 1'b1) chk(16'h0001, 16'h0000);
        end
        eoi_pri = 1'b1;
        eoi_sec = sec;
        tick(1);
        eoi_pri = 1'b0;
        eoi_sec = 1'b0;
    endtask
    task t_reset;
        chk(mask_out, 16'hffff);
        chk({8'h00, nmi_vector}, 16'h0002);
        en = 1'b1;
        irq_pin = 16'hffff;
        tick(12);
        chk({15'h0000, int_out}, 16'h0000);
        irq_pin = 16'h0000;
        en = 1'b0;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(2);
    endtask
    task t_side;
        smi_pin = 1'b1;
        chan_chk_pin = 1'b1;
        tick(8);
        chk({14'h0000, smi_out, nmi_out}, 16'h0003);
        smi_pin = 1'b0;
        chan_chk_pin = 1'b0;
        tick(8);
        chk({14'h0000, smi_out, nmi_out}, 16'h0000);
    endtask
    task t_prio;
        set_mask(16'h0000);
        en = 1'b1;
        irq_pin = 16'h8109;
        serve(8'h08, 1'b0);
        serve(8'h70, 1'b1);
        chk({8'h00, soft_vec}, 16'h0070);
        serve(8'h77, 1'b1);
        serve(8'h0b, 1'b0);
        irq_pin = 16'h0000;
    endtask
    task t_casc;
        set_mask(16'hfdff);
        lat = 4'h9;
        irq_pin = 16'h0200;
        tick(14);
        chk({15'h0000, int_out}, 16'h0000);
        set_mask(16'hfdfb);
        serve(8'h71, 1'b1);
        chk({8'h00, soft_vec}, 16'h000a);
        irq_pin = 16'h0000;
    endtask
    task finish_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        tick(10);
        rst_n = 1'b1;
        tick(2);
        t_reset;
        t_side;
        t_prio;
        t_casc;
        finish_test();
    end
endmodule
bind cipu_top cipu_sva cipu_sva_i (.clk, .rst_n, .chan_chk_pin, .smi_pin,
    .mask_wr, .inta, .int_out, .vector_out, .vector_valid, .nmi_out,
    .nmi_vector, .smi_out, .mask_out);
`default_nettype wire
